// [shared/tcc_pkg.sv]
// Constants and types for the trace capture controller.
// Assumes a single 40 MHz sample clock; registers reached over a plain strobe port.
// Function
// R1: Row matches when all defined bits agree
// R2: External event is OR of enabled rows
// R3: Pattern bit i watches channel i
// R4: Buffer depth 32768, pointer sized to fit
// R5: Start on run, event, counter, sequence
// R6: Events A to D selectable as start
// R7: Stop on event, counter, sequence, length
// R8: Stop halts writes until next start
// R9: Disable on event, counter, sequence, full, length
// R10: Disabled trace ignores starts until reenabled
// R11: Host reenables via command without download
// R12: Full buffer disables or requests breakpoint
// R13: One high, zero low, X masks
// R14: Inclusive inside with ends, exclusive outside
// R15: Length loads on start, decrements, acts at zero
// R16: Disable beats start in same cycle
package tcc_pkg;
	localparam int unsigned CH_W        = 16;
	localparam int unsigned ROWS        = 4;
	localparam int unsigned DEPTH       = 32768;
	localparam int unsigned PTR_W       = 15;
	localparam int unsigned SAMPLE_W    = 32;
	localparam logic [3:0]  RA_ROW_BASE = 4'h0; // Rows 0..3: pattern care/level
	localparam logic [3:0]  RA_RANGE    = 4'h4; // Range beg/end
	localparam logic [3:0]  RA_SRC      = 4'h5; // Start/stop/disable source select
	localparam logic [3:0]  RA_LEN      = 4'h6;
	localparam logic [3:0]  RA_CTRL     = 4'h7;
	localparam logic [3:0]  RA_STAT     = 4'h8;
	localparam logic [3:0]  RA_IRQ      = 4'h9;
	localparam logic [3:0]  RA_MASK     = 4'hA;
	localparam logic [3:0]  RA_PTR      = 4'hB;
	// Source select positions: start/stop/disable fields of 8 bits each (run,A,B,C,D,cnt,seq,len); full disable and full break are single bits
	localparam int unsigned SRC_START   = 0;
	localparam int unsigned SRC_STOP    = 8;
	localparam int unsigned SRC_DIS     = 16;
	localparam int unsigned SRC_FULL_DIS = 24;
	localparam int unsigned SRC_FULL_BRK = 25;
	// Control bits
	localparam int unsigned CTL_ROW_EN  = 0;  // 4 bits
	localparam int unsigned CTL_INCLUSIVE_RANGE_MODE    = 4;
	localparam int unsigned CTL_RANGE_EN = 5;
	localparam int unsigned CTL_REEN    = 8;  // Write one: reenable command
	localparam int unsigned CTL_CLR     = 9;  // Write one: reset pointer and full
	// Interrupt status bits
	localparam int unsigned IRQ_FULL    = 0;
	localparam int unsigned IRQ_DIS     = 1;
	localparam int unsigned IRQ_BRK     = 2;
	localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
	typedef enum logic [1:0] {
		TCC_IDLE = 2'b00,
		TCC_RUN  = 2'b01,
		TCC_DIS  = 2'b11
	} tcc_state_e;
endpackage

// [hw/tcc_trace_capture.sv]
// Trace capture controller: pattern events, start/stop/disable control, buffer.
// Assumes probes are asynchronous, event inputs are on sys_clk.
`timescale 1ns/1ps
module tcc_trace_capture
	import tcc_pkg::*;
#(
	parameter int unsigned SW = tcc_pkg::SAMPLE_W
)
(
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	input  wire logic [tcc_pkg::CH_W-1:0] probe_in,
	input  wire logic [SW-1:0]           bus_sample,
	input  wire logic                    target_running,
	input  wire logic [3:0]              event_bus,
	input  wire logic                    counter_zero,
	input  wire logic                    sequence_done,
	input  wire logic [3:0]              reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [31:0]             reg_rdata,
	output logic                         hw_break_req,
	output logic                         irq,
	output logic                         trace_active
);
	//////////////////////////////////////////////////////////////////////////////
	// Functions
	function automatic logic row_hit(input logic [CH_W-1:0] care, input logic [CH_W-1:0] lvl,
		input logic [CH_W-1:0] ch);
		row_hit = ((ch ~^ lvl) & care) == care; // [R1] [R3] [R13]
	endfunction

	function automatic logic sel_hit(input logic [7:0] sel, input logic [7:0] src);
		sel_hit = |(sel & src);
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [CH_W-1:0]  care_r [ROWS];
	logic [CH_W-1:0]  lvl_r  [ROWS];
	logic [31:0]      range_r;
	logic [31:0]      src_r;
	logic [PTR_W:0]   len_r;
	logic [7:0]       ctrl_r;
	logic [2:0]       stat_r;
	logic [2:0]       mask_r;
	logic [CH_W-1:0]  probe_s1_r;
	logic [CH_W-1:0]  probe_s2_r;
	logic             run_d_r;
	logic             started_r;
	logic [PTR_W:0]   cnt_r;
	logic [PTR_W-1:0] wptr_r;
	logic             full_r;
	logic             break_r;
	logic [31:0]      rdata_r;
	logic [SW-1:0]    mem_r [DEPTH];
	tcc_state_e       state_r;
	tcc_state_e       state_nxt;

	//////////////////////////////////////////////////////////////////////////////
	// Probe synchroniser
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			probe_s1_r <= '0;
			probe_s2_r <= '0;
		end
		else
		begin
			probe_s1_r <= probe_in;
			probe_s2_r <= probe_s1_r;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Event forming
	logic [ROWS-1:0] row_match;
	genvar gi;
	generate
		for (gi = 0; gi < ROWS; gi++)
		begin : g_row
			assign row_match[gi] = ctrl_r[CTL_ROW_EN+gi] & row_hit(care_r[gi], lvl_r[gi], probe_s2_r);
		end
	endgenerate
	wire [15:0] rng_beg   = range_r[15:0];
	wire [15:0] rng_end   = range_r[31:16];
	wire        in_range  = (probe_s2_r >= rng_beg) && (probe_s2_r <= rng_end);
	wire        out_range = (probe_s2_r < rng_beg) || (probe_s2_r > rng_end);
	wire        range_ok  = !ctrl_r[CTL_RANGE_EN] ||
		(ctrl_r[CTL_INCLUSIVE_RANGE_MODE] ? in_range : out_range);                       // [R14]
	wire        ext_event = (|row_match) & range_ok;                     // [R2]
	// Event A also carries the external-channel event
	wire [3:0]  events    = event_bus | {3'b000, ext_event};

	//////////////////////////////////////////////////////////////////////////////
	// Condition decode
	wire        run_rise  = target_running & ~run_d_r;
	wire        len_zero  = started_r && (cnt_r == '0);
	wire [7:0]  srcs      = {len_zero, sequence_done, counter_zero, events, run_rise};
	wire        start_c   = sel_hit(src_r[SRC_START+:8], {1'b0, srcs[6:0]}); // [R5] [R6]
	wire        stop_c    = sel_hit(src_r[SRC_STOP+:8], srcs);                // [R7]
	wire        full_dis  = full_r & src_r[SRC_FULL_DIS];
	wire        dis_c     = sel_hit(src_r[SRC_DIS+:8], srcs) | full_dis;      // [R9] [R12]
	wire        reen_cmd  = reg_wr && reg_addr == RA_CTRL && reg_wdata[CTL_REEN]; // [R11]
	wire        clr_cmd   = reg_wr && reg_addr == RA_CTRL && reg_wdata[CTL_CLR];
	wire        writing   = (state_r == TCC_RUN) && !full_r && !dis_c && !stop_c; // [R16]

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			TCC_IDLE:
			begin
				if (dis_c)
					state_nxt = TCC_DIS;                                   // [R16]
				else if (start_c)
					state_nxt = TCC_RUN;                                   // [R5]
			end
			TCC_RUN:
			begin
				if (dis_c)
					state_nxt = TCC_DIS;                                   // [R9]
				else if (stop_c)
					state_nxt = TCC_IDLE;                                  // [R8]
			end
			TCC_DIS:
			begin
				// Later starts are ignored here
				if (reen_cmd)
					state_nxt = TCC_RUN;                                   // [R10]
			end
			default:
				state_nxt = TCC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= TCC_IDLE;
		else
			state_r <= state_nxt;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Length counter
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r     <= '0;
			started_r <= 1'b0;
			run_d_r   <= 1'b0;
		end
		else
		begin
			run_d_r <= target_running;
			if (start_c && state_r != TCC_DIS)
			begin
				cnt_r     <= len_r;                                        // [R15]
				started_r <= 1'b1;
			end
			else if (len_zero)
				started_r <= 1'b0;
			else if (writing && cnt_r != '0)
				cnt_r <= cnt_r - 1'b1;                                     // [R15]
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Buffer write
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wptr_r  <= '0;
			full_r  <= 1'b0;
		end
		else
		begin
			if (clr_cmd)
			begin
				wptr_r <= '0;
				full_r <= 1'b0;
			end
			else if (writing)
			begin
				wptr_r <= wptr_r + 1'b1;                                   // [R4]
				if (wptr_r == PTR_W'(DEPTH - 1))
					full_r <= 1'b1;
			end
		end
	end

	// Breakpoint request holds until clear or reenable
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			break_r <= 1'b0;
		else if (clr_cmd || reen_cmd)
			break_r <= 1'b0;
		else if (full_r && src_r[SRC_FULL_BRK])
			break_r <= 1'b1;                                               // [R12]
	end

	always_ff @(posedge sys_clk)
	begin
		if (writing)
			mem_r[wptr_r] <= bus_sample;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Register port
	// Status events are one-cycle pulses, not levels
	wire        full_evt  = writing && (wptr_r == PTR_W'(DEPTH - 1));
	wire        dis_evt   = (state_nxt == TCC_DIS) && (state_r != TCC_DIS);
	wire        brk_evt   = full_r && src_r[SRC_FULL_BRK] && !break_r && !clr_cmd && !reen_cmd;
	wire [2:0]  irq_ev    = {brk_evt, dis_evt, full_evt};
	wire        rd_row    = reg_addr < RA_RANGE;
	wire [1:0]  row_ix    = reg_addr[1:0];
	wire        wr_row    = reg_wr && rd_row;
	wire        wr_range  = reg_wr && (reg_addr == RA_RANGE);
	wire        wr_src    = reg_wr && (reg_addr == RA_SRC);
	wire        wr_len    = reg_wr && (reg_addr == RA_LEN);
	wire        wr_ctrl   = reg_wr && (reg_addr == RA_CTRL);
	wire        wr_irq    = reg_wr && (reg_addr == RA_IRQ);
	wire        wr_mask   = reg_wr && (reg_addr == RA_MASK);
	wire [2:0]  irq_clr   = wr_irq ? reg_wdata[2:0] : 3'b000;
	// Event set wins over write-one clear
	wire [2:0]  stat_nxt  = (stat_r & ~irq_clr) | irq_ev;
	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = RST_ZERO;
		case (reg_addr)
			RA_ROW_BASE, 4'h1, 4'h2, 4'h3:
				rd_mux = {care_r[row_ix], lvl_r[row_ix]};
			RA_RANGE:
				rd_mux = range_r;
			RA_SRC:
				rd_mux = src_r;
			RA_LEN:
				rd_mux = {16'h0000, len_r};
			RA_CTRL:
				rd_mux = {24'h000000, ctrl_r};
			RA_STAT:
				rd_mux = {12'h000, cnt_r, full_r, break_r, state_r};
			RA_IRQ:
				rd_mux = {29'h0000000, stat_r};
			RA_MASK:
				rd_mux = {29'h0000000, mask_r};
			RA_PTR:
				rd_mux = {17'h00000, wptr_r};
			default:
				rd_mux = RST_ZERO;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < ROWS; i++)
			begin
				care_r[i] <= '0;
				lvl_r[i]  <= '0;
			end
		end
		else if (wr_row)
		begin
			care_r[row_ix] <= reg_wdata[31:16];
			lvl_r[row_ix]  <= reg_wdata[15:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			range_r <= RST_ZERO;
		else if (wr_range)
			range_r <= reg_wdata;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			src_r <= RST_ZERO;
		else if (wr_src)
			src_r <= reg_wdata;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			len_r <= '0;
		else if (wr_len)
			len_r <= reg_wdata[PTR_W:0];
	end

	// Command bits 8 and 9 are not stored
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_r <= '0;
		else if (wr_ctrl)
			ctrl_r <= {2'b00, reg_wdata[5:0]};
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			mask_r <= '0;
		else if (wr_mask)
			mask_r <= reg_wdata[2:0];
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			stat_r <= '0;
		else
			stat_r <= stat_nxt;
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= RST_ZERO;
		else
			rdata_r <= reg_rd ? rd_mux : RST_ZERO;
	end

	assign reg_rdata    = rdata_r;
	assign irq          = |(stat_r & mask_r);
	assign hw_break_req = break_r;
	assign trace_active = (state_r == TCC_RUN);
endmodule

// [sim/tcc_trace_chk.sv]
// Port checker for the trace capture controller.
// Assumes bind into tcc_trace_capture; mask and sources are shadowed here.
`timescale 1ns/1ps
module tcc_trace_chk
	import tcc_pkg::*;
(
	input	wire logic		sys_clk,
	input	wire logic		rst_n,
	input	wire logic		counter_zero,
	input	wire logic	[3:0]	reg_addr,
	input	wire logic	[31:0]	reg_wdata,
	input	wire logic		reg_wr,
	input	wire logic		reg_rd,
	input	wire logic	[31:0]	reg_rdata,
	input	wire logic		hw_break_req,
	input	wire logic		irq,
	input	wire logic		trace_active
);
	logic	[31:0]	mask_r;
	logic	[31:0]	src_r;
	logic		dis_r;
	wire		ctl_wr	= reg_wr && reg_addr == RA_CTRL;
	wire		reen	= ctl_wr && reg_wdata[CTL_REEN];
	wire		dis_hit	= trace_active && counter_zero && src_r[SRC_DIS+5];
	wire		st_rd	= reg_rd && reg_addr == RA_STAT;
	////////////////////////////////
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			mask_r <= RST_ZERO;
		else if (reg_wr && reg_addr == RA_MASK)
			mask_r <= reg_wdata;
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			src_r <= RST_ZERO;
		else if (reg_wr && reg_addr == RA_SRC)
			src_r <= reg_wdata;
	// Counter-zero disable seen, until reenabled
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			dis_r <= 1'b0;
		else
			dis_r <= !reen && (dis_hit || dis_r);
	////////////////////////////////
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == RST_ZERO)
		else $error("read data outside answer cycle");
	chk_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > RA_PTR |-> !reg_rdata)
		else $error("unmapped read not zero");
	chk_state_code: assert property ($past(st_rd) |-> reg_rdata[1:0] != 2'b10)
		else $error("bad state code");
	chk_state_active: assert property ($past(st_rd) |-> (reg_rdata[1:0] == 2'b01) == $past(trace_active))
		else $error("state and active disagree");
	chk_dis_first: assert property (dis_hit |=> !trace_active)
		else $error("disable did not stop trace");
	chk_dis_holds: assert property (dis_r && !reen |=> !trace_active)
		else $error("trace resumed while disabled");
	chk_break_holds: assert property (hw_break_req && !(ctl_wr && reg_wdata[CTL_CLR]) |=> hw_break_req)
		else $error("break dropped without clear");
	chk_break_clear: assert property (ctl_wr && reg_wdata[CTL_CLR] |-> ##[1:2] !hw_break_req)
		else $error("break not cleared");
	chk_irq_mask: assert property (mask_r[2:0] == 3'h0 |-> !irq)
		else $error("irq with all masked");
endmodule
bind tcc_trace_capture tcc_trace_chk i_chk (.*);

// [sim/tcc_target_model.sv]
// Far-side stand-in: probe channels and a counting bus stream.
// Assumes the bench sets the probe levels.
`timescale 1ns/1ps
module tcc_target_model
(
	input	wire logic		sys_clk,
	input	wire logic	[15:0]	probe_lvl,
	output	logic		[15:0]	probe_in,
	output	logic		[31:0]	bus_sample
);
	logic	[31:0]	cnt_r = 32'h0;
	assign probe_in = probe_lvl;
	assign bus_sample = cnt_r;
	always_ff @(posedge sys_clk)
		cnt_r <= cnt_r + 32'h1;
endmodule

// [sim/test_trace_capture_control.sv]
// Testbench for the trace capture controller.
// Assumes the checker and target model compile first.
`timescale 1ns/1ps
module test_trace_capture_control;
	import tcc_pkg::*;
	logic		sys_clk = 1'b0;
	logic		rst_n = 1'b0;
	logic		target_running = 1'b0;
	logic		counter_zero = 1'b0;
	logic		sequence_done = 1'b0;
	logic		reg_wr = 1'b0;
	logic		reg_rd = 1'b0;
	logic	[3:0]	event_bus = 4'h0;
	logic	[3:0]	reg_addr = 4'h0;
	logic	[31:0]	reg_wdata = 32'h0;
	logic	[15:0]	probe_lvl = 16'h2004;
	logic	[15:0]	probe_in;
	logic	[31:0]	bus_sample;
	logic	[31:0]	reg_rdata;
	logic	[31:0]	rv;
	logic		hw_break_req;
	logic		irq;
	logic		trace_active;
	int		num_errors = 0;
	int		checks_done = 0;
	always #12.5 sys_clk = ~sys_clk;
	tcc_target_model i_tgt (.sys_clk(sys_clk), .probe_lvl(probe_lvl), .probe_in(probe_in),
		.bus_sample(bus_sample));
	tcc_trace_capture i_dut (
		.sys_clk        (sys_clk),
		.rst_n          (rst_n),
		.probe_in       (probe_in),
		.bus_sample     (bus_sample),
		.target_running (target_running),
		.event_bus      (event_bus),
		.counter_zero   (counter_zero),
		.sequence_done  (sequence_done),
		.reg_addr       (reg_addr),
		.reg_wdata      (reg_wdata),
		.reg_wr         (reg_wr),
		.reg_rd         (reg_rd),
		.reg_rdata      (reg_rdata),
		.hw_break_req   (hw_break_req),
		.irq            (irq),
		.trace_active   (trace_active)
	);
	////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wt(input string nm, ref logic s, input logic exp, input int n);
		checks_done++;
		repeat (n)
		begin
			@(negedge sys_clk);
			if (s === exp)
				return;
		end
		num_errors++;
		$display("wrong value %s expected %b seen %b", nm, exp, s);
		tally_and_finish();
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		rv = reg_rdata;
	endtask
	// Bits: sequence, counter, events D..A
	task automatic pulse(input logic [5:0] v);
		@(posedge sys_clk);
		{sequence_done, counter_zero, event_bus} <= v;
		@(posedge sys_clk);
		{sequence_done, counter_zero, event_bus} <= 6'h00;
	endtask
	task automatic probe(input logic [15:0] v);
		@(posedge sys_clk);
		probe_lvl <= v;
		repeat (6) @(negedge sys_clk);
	endtask
	////////////////////////////////
	task automatic t_pattern();
		wr(RA_ROW_BASE, 32'h00A0_00A0);
		wr(RA_ROW_BASE + 4'h1, 32'h2004_0000);
		wr(RA_SRC, 32'h0000_4002);
		wr(RA_CTRL, 32'h0000_0003);
		probe(16'h2024);
		chk("partial row", trace_active, 0);
		probe(16'h20A4);
		wt("row and", trace_active, 1, 8);
		probe(16'h2004);
		pulse(6'h20);
		wt("stop", trace_active, 0, 8);
		probe(16'h0000);
		wt("row or", trace_active, 1, 8);
		probe(16'h2004);
		pulse(6'h20);
		wt("stop again", trace_active, 0, 8);
		$display("pattern test done");
	endtask
	task automatic t_disable();
		wr(RA_MASK, 32'h0000_0002);
		wr(RA_SRC, 32'h0020_0040);
		pulse(6'h30);
		repeat (4) @(negedge sys_clk);
		chk("start with disable", trace_active, 0);
		chk("disable irq", irq, 1);
		rd(RA_STAT);
		chk("state", rv[1:0], 2'b11);
		wr(RA_IRQ, 32'h0000_0002);
		@(negedge sys_clk);
		chk("irq cleared", irq, 0);
		wr(RA_CTRL, 32'h0000_0100);
		wt("reenable", trace_active, 1, 4);
		pulse(6'h10);
		wt("counter disable", trace_active, 0, 4);
		pulse(6'h20);
		repeat (4) @(negedge sys_clk);
		chk("start ignored", trace_active, 0);
		$display("disable test done");
	endtask
	task automatic t_len_range();
		logic [31:0] p0;
		wr(RA_CTRL, 32'h0000_0200);
		wr(RA_SRC, 32'h0000_C001);
		wr(RA_LEN, 32'h0000_0003);
		wr(RA_CTRL, 32'h0000_0100);
		wt("len reenable", trace_active, 1, 4);
		pulse(6'h20);
		wt("len idle", trace_active, 0, 8);
		rd(RA_PTR);
		p0 = rv;
		@(posedge sys_clk);
		target_running <= 1'b1;
		wt("run start", trace_active, 1, 8);
		wt("len stop", trace_active, 0, 16);
		rd(RA_PTR);
		chk("len samples", rv - p0, 32'h0000_0003);
		wr(RA_RANGE, 32'h20A4_2000);
		wr(RA_SRC, 32'h0000_4002);
		wr(RA_CTRL, 32'h0000_0021);
		probe(16'h20A4);
		chk("exclusive end", trace_active, 0);
		wr(RA_CTRL, 32'h0000_0031);
		wt("inclusive end", trace_active, 1, 8);
		probe(16'h2004);
		pulse(6'h20);
		wt("range stop", trace_active, 0, 8);
		$display("length and range test done");
	endtask
	task automatic t_full();
		wr(RA_SRC, 32'h0200_0040);
		wr(RA_CTRL, 32'h0000_0200);
		pulse(6'h20);
		repeat (32700) @(negedge sys_clk);
		chk("early break", hw_break_req, 0);
		wt("full break", hw_break_req, 1, 200);
		wr(RA_CTRL, 32'h0000_0200);
		wt("break cleared", hw_break_req, 0, 4);
		$display("full test done");
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(4'hF);
		chk("unmapped", rv, RST_ZERO);
		t_pattern();
		t_disable();
		t_len_range();
		t_full();
		tally_and_finish();
	end
endmodule
